//--- scpc_pkg.sv
package scpc_pkg;
	typedef enum logic [1:0] {
		SCPC_SYNC8      = 2'b00,
		SCPC_ASYNC10    = 2'b01,
		SCPC_ASYNC11_CK = 2'b10,
		SCPC_ASYNC11_TM = 2'b11
	} scpc_mode_t;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_IRQ_EN   = 8'h01;
	localparam logic [7:0] IDX_PWR_BAUD = 8'h87;
	localparam logic [7:0] IDX_SP0_CTL  = 8'h98;
	localparam logic [7:0] IDX_TMR3_CTL = 8'hc4;
	localparam logic [7:0] IDX_SP1_CTL  = 8'hf8;
	localparam int         BYTE_ADDR_W  = 10;

	// control byte layout
	localparam int B_MODE_HI = 7;
	localparam int B_MODE_LO = 6;
	localparam int B_MP_EN   = 5;
	localparam int B_REN     = 4;
	localparam int B_TB8     = 3;
	localparam int B_RB8     = 2;
	localparam int B_TI      = 1;
	localparam int B_RI      = 0;
	// baud and frame-error access bits of the power and timer 3 bytes
	localparam int B_BAUD_DBL = 7;
	localparam int B_FE_SEL   = 6;

	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [3:0] LEN_SYNC = 4'h8;
	localparam logic [3:0] LEN_10   = 4'ha;
	localparam logic [3:0] LEN_11   = 4'hb;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- scpc_port_if.sv
`timescale 1ns/100ps
interface scpc_port_if;
	logic                 wr_en;    // software write of the control byte
	logic [7:0]           wr_data;  // byte written
	logic                 fe_sel;   // top bit reaches the frame error flag
	logic                 rx_done;  // frame received, one-cycle pulse
	logic                 rx_stop;  // sampled stop bit
	logic                 rx_ninth; // received ninth bit
	logic                 rx_match; // given or broadcast address matched
	logic                 tx_done;  // frame sent, one-cycle pulse
	logic [7:0]           view;     // control byte as software reads it
	scpc_pkg::scpc_mode_t mode;     // operating mode
	logic                 rx_allow; // reception may proceed
	logic                 tx_ninth; // ninth bit to send

	modport owner (output wr_en, wr_data, fe_sel, rx_done, rx_stop,
		rx_ninth, rx_match, tx_done, input view, mode, rx_allow, tx_ninth);
	modport port (input wr_en, wr_data, fe_sel, rx_done, rx_stop,
		rx_ninth, rx_match, tx_done, output view, mode, rx_allow, tx_ninth);
endinterface

//--- scpc_port_ctl.sv
`timescale 1ns/100ps
module scpc_port_ctl (
	input  wire logic clk, // system clock
	input  wire logic rst, // asynchronous reset, active high
	scpc_port_if.port pif  // control byte and line events
);
	logic       mode_hi_ff;
	logic [3:0] sw_ff;
	logic       rb8_ff;
	logic       ti_ff;
	logic       ri_ff;
	logic       fe_ff;
	logic       async_mode;
	logic       chk_bit;
	logic       accept;

	assign pif.mode = scpc_pkg::scpc_mode_t'({mode_hi_ff, sw_ff[3]});
	assign async_mode = pif.mode != scpc_pkg::SCPC_SYNC8;
	assign chk_bit = (pif.mode == scpc_pkg::SCPC_ASYNC10) ?
		pif.rx_stop : pif.rx_ninth;
	// multiprocessor check only applies to asynchronous frames
	assign accept = pif.rx_done && (!async_mode || !sw_ff[2] ||
		(chk_bit && pif.rx_match));
	assign pif.rx_allow = sw_ff[1] && (async_mode || !ri_ff);
	assign pif.tx_ninth = pif.mode[1] ? sw_ff[0] : 1'b1;
	assign pif.view = {pif.fe_sel ? fe_ff : mode_hi_ff, sw_ff[3:1],
		sw_ff[0], rb8_ff, ti_ff, ri_ff};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_hi_ff <= scpc_pkg::RST_CTL[scpc_pkg::B_MODE_HI];
			sw_ff <= scpc_pkg::RST_CTL[scpc_pkg::B_MODE_LO:scpc_pkg::B_TB8];
		end else if (pif.wr_en) begin
			if (!pif.fe_sel) begin
				mode_hi_ff <= pif.wr_data[scpc_pkg::B_MODE_HI];
			end
			sw_ff <= pif.wr_data[scpc_pkg::B_MODE_LO:scpc_pkg::B_TB8];
		end
	end

	// hardware sets win over a software write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fe_ff <= 1'b0;
		end else if (pif.rx_done && async_mode && !pif.rx_stop) begin
			fe_ff <= 1'b1;
		end else if (pif.wr_en && pif.fe_sel) begin
			fe_ff <= pif.wr_data[scpc_pkg::B_MODE_HI];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ri_ff <= 1'b0;
			rb8_ff <= 1'b0;
		end else begin
			if (accept) begin
				ri_ff <= 1'b1;
			end else if (pif.wr_en) begin
				ri_ff <= pif.wr_data[scpc_pkg::B_RI];
			end
			if (accept && async_mode) begin
				rb8_ff <= chk_bit;
			end else if (pif.wr_en) begin
				rb8_ff <= pif.wr_data[scpc_pkg::B_RB8];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ti_ff <= 1'b0;
		end else if (pif.tx_done) begin
			ti_ff <= 1'b1;
		end else if (pif.wr_en) begin
			ti_ff <= pif.wr_data[scpc_pkg::B_TI];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_rx_flag_set: assert property (
		pif.rx_done && (!async_mode || !sw_ff[2]) |=> ri_ff
	) else $error("receive flag not set after accepted frame");
	chk_mp_reject: assert property (
		pif.rx_done && async_mode && sw_ff[2] && !chk_bit && !ri_ff &&
		!pif.wr_en |=> !ri_ff ##0 $stable(rb8_ff)
	) else $error("frame failing address check was accepted");
	chk_tx_flag_set: assert property (
		pif.tx_done |=> ti_ff
	) else $error("transmit flag not set after frame");
	chk_rb8_stop: assert property (
		pif.rx_done && pif.mode == scpc_pkg::SCPC_ASYNC10 && !sw_ff[2]
		|=> rb8_ff == $past(pif.rx_stop)
	) else $error("ninth receive bit not loaded with stop bit");
	chk_frame_err: assert property (
		pif.rx_done && async_mode && !pif.rx_stop |=> fe_ff ##1
		(fe_ff || $past(pif.wr_en && pif.fe_sel))
	) else $error("frame error flag not set or lost");
endmodule

//--- scpc_top.sv
`timescale 1ns/100ps
// Behaviour
// - with frame-error access off, control bits 7 and 6 select mode
// - modes: 00 sync 8-bit, 01 async 10-bit, 10/11 async 11-bit
// - with frame-error access on, control bit 7 reads and writes the flag
// - frame error sets the flag; reads 0 otherwise; cleared by write only
// - mode 1 multiprocessor on: accept only with stop 1 and address match
// - modes 2, 3 multiprocessor on: accept only ninth bit 1 and match
// - receive enable 0 blocks reception; 1 enables it in modes 1 to 3
// - mode 0 reception starts only with receive enable 1 and flag 0
// - modes 2, 3 send the ninth transmit bit; modes 0, 1 ignore it
// - ninth receive bit takes ninth bit in modes 2, 3 or stop bit in mode 1; mode 0 leaves it unchanged
// - transmit flag set at frame end; only software clears it
// - receive flag set at frame end, subject to the address check
// - enabled interrupt is requested while transmit or receive flag set
// - port 0 doubling in mode 2, and modes 1, 3 on timer 1
// - port 0 frame-error access routes control bit 7 like port 1
// - port 1 doubling in mode 2 selects clock over 32, not 64
module scpc_top #(
	parameter int ADDR_W = 12 // AXI address width
) (
	input  wire logic              clk,            // system clock, 25 MHz
	input  wire logic              rst,            // async reset, active high
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
	input  wire logic              s_axi_awvalid,  // write address valid
	output logic                   s_axi_awready,  // write address ready
	input  wire logic [31:0]       s_axi_wdata,    // write data
	input  wire logic [3:0]        s_axi_wstrb,    // write byte lanes
	input  wire logic              s_axi_wvalid,   // write data valid
	output logic                   s_axi_wready,   // write data ready
	output logic [1:0]             s_axi_bresp,    // write response
	output logic                   s_axi_bvalid,   // write response valid
	input  wire logic              s_axi_bready,   // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
	input  wire logic              s_axi_arvalid,  // read address valid
	output logic                   s_axi_arready,  // read address ready
	output logic [31:0]            s_axi_rdata,    // read data
	output logic [1:0]             s_axi_rresp,    // read response
	output logic                   s_axi_rvalid,   // read data valid
	input  wire logic              s_axi_rready,   // read data ready
	input  wire logic [1:0]        rx_done,        // frame received, per port
	input  wire logic [1:0]        rx_stop,        // sampled stop bit
	input  wire logic [1:0]        rx_ninth,       // received ninth bit
	input  wire logic [1:0]        rx_match,       // address matched
	input  wire logic [1:0]        tx_done,        // frame sent, per port
	input  wire logic              p0_timer1_src,  // port 0 baud from timer 1
	output logic [1:0][1:0]        port_mode,      // mode of each port
	output logic [1:0]             rx_enable,      // reception allowed
	output logic [1:0]             tx_ninth,       // ninth bit to send
	output logic [1:0]             irq_req,        // interrupt request
	output logic                   p0_baud_double, // port 0 rate doubled
	output logic                   p1_div32,       // port 1 clock over 32
	output logic                   p1_clk_timer3,  // port 1 baud from timer 3
	output logic [3:0]             p1_frame_len    // port 1 frame bits
);
	localparam int AW = scpc_pkg::BYTE_ADDR_W;

	if (ADDR_W <= AW) begin : g_bad_addr_w
		$error("ADDR_W must exceed the decoded byte address width");
	end

	logic              awready_ff;
	logic              wready_ff;
	logic              aw_hold_ff;
	logic              w_hold_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [7:0]        w_data_ff;
	logic              w_strb_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [1:0]        rresp_ff;
	logic [7:0]        rdata_ff;
	logic              nxt_aw_hold;
	logic              nxt_w_hold;
	logic              nxt_bvalid;
	logic              nxt_rvalid;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              wr_fire;
	logic              wr_ok;
	logic              wr_sel;
	logic [7:0]        wr_idx;
	logic [7:0]        rd_idx;
	logic              rd_ok;
	logic [7:0]        rd_byte;
	logic [1:0]        baud_dbl_ff;
	logic [1:0]        fe_sel_ff;
	logic [1:0]        irq_en_ff;
	logic [1:0][1:0]   mode_ff;
	logic [1:0]        rx_enable_ff;
	logic [1:0]        tx_ninth_ff;
	logic [1:0]        irq_req_ff;
	logic              p0_dbl_ff;
	logic              p1_div32_ff;
	logic              p1_tmr3_ff;
	logic [3:0]        p1_len_ff;
	logic [1:0][7:0]   view_w;
	logic [1:0][1:0]   mode_w;
	logic [1:0]        allow_w;
	logic [1:0]        ninth_w;

	function automatic logic idx_hit(input logic [7:0] idx);
		idx_hit = idx inside {scpc_pkg::IDX_IRQ_EN, scpc_pkg::IDX_PWR_BAUD,
			scpc_pkg::IDX_SP0_CTL, scpc_pkg::IDX_TMR3_CTL,
			scpc_pkg::IDX_SP1_CTL};
	endfunction

	function automatic logic [3:0] frame_len(input logic [1:0] mode);
		unique case (mode)
			2'b00: frame_len = scpc_pkg::LEN_SYNC;
			2'b01: frame_len = scpc_pkg::LEN_10;
			2'b10: frame_len = scpc_pkg::LEN_11;
			2'b11: frame_len = scpc_pkg::LEN_11;
		endcase
	endfunction

	// write channel: address and data held until both are in, then one
	// write; nothing new is taken until the response has been accepted
	assign aw_take = s_axi_awvalid && awready_ff;
	assign w_take = s_axi_wvalid && wready_ff;
	assign wr_fire = aw_hold_ff && w_hold_ff;
	assign nxt_aw_hold = aw_take || (aw_hold_ff && !wr_fire);
	assign nxt_w_hold = w_take || (w_hold_ff && !wr_fire);
	assign nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);
	assign wr_idx = aw_addr_ff[AW-1:2];
	assign wr_ok = idx_hit(wr_idx) && (aw_addr_ff[ADDR_W-1:AW] == '0);
	assign wr_sel = wr_fire && wr_ok && w_strb_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= scpc_pkg::RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awready_ff <= !nxt_aw_hold && !nxt_bvalid;
			wready_ff <= !nxt_w_hold && !nxt_bvalid;
			bvalid_ff <= nxt_bvalid;
			if (wr_fire) begin
				bresp_ff <= wr_ok ? scpc_pkg::RESP_OKAY :
					scpc_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_addr_ff <= '0;
			w_data_ff <= 8'h00;
			w_strb_ff <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata[7:0];
				w_strb_ff <= s_axi_wstrb[0];
			end
		end
	end

	// read channel: data is looked up in the cycle the address is taken
	assign ar_take = s_axi_arvalid && arready_ff;
	assign nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);

	always_comb begin
		rd_idx = s_axi_araddr[AW-1:2];
		rd_ok = idx_hit(rd_idx) && (s_axi_araddr[ADDR_W-1:AW] == '0);
		rd_byte = 8'h00;
		case (rd_idx)
			scpc_pkg::IDX_IRQ_EN:   rd_byte = {6'h00, irq_en_ff};
			scpc_pkg::IDX_PWR_BAUD: rd_byte = {baud_dbl_ff[0], fe_sel_ff[0],
				6'h00};
			scpc_pkg::IDX_TMR3_CTL: rd_byte = {baud_dbl_ff[1], fe_sel_ff[1],
				6'h00};
			scpc_pkg::IDX_SP0_CTL:  rd_byte = view_w[0];
			scpc_pkg::IDX_SP1_CTL:  rd_byte = view_w[1];
			default:                rd_byte = 8'h00;
		endcase
		if (!rd_ok) begin
			rd_byte = 8'h00;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rresp_ff <= scpc_pkg::RESP_OKAY;
			rdata_ff <= 8'h00;
		end else begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rd_byte;
				rresp_ff <= rd_ok ? scpc_pkg::RESP_OKAY :
					scpc_pkg::RESP_SLVERR;
			end
		end
	end

	// baud doubling, frame-error access and interrupt enables
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baud_dbl_ff <= 2'h0;
			fe_sel_ff <= 2'h0;
			irq_en_ff <= 2'h0;
		end else if (wr_sel) begin
			if (wr_idx == scpc_pkg::IDX_PWR_BAUD) begin
				baud_dbl_ff[0] <= w_data_ff[scpc_pkg::B_BAUD_DBL];
				fe_sel_ff[0] <= w_data_ff[scpc_pkg::B_FE_SEL];
			end
			if (wr_idx == scpc_pkg::IDX_TMR3_CTL) begin
				baud_dbl_ff[1] <= w_data_ff[scpc_pkg::B_BAUD_DBL];
				fe_sel_ff[1] <= w_data_ff[scpc_pkg::B_FE_SEL];
			end
			if (wr_idx == scpc_pkg::IDX_IRQ_EN) begin
				irq_en_ff <= w_data_ff[1:0];
			end
		end
	end

	scpc_port_if pif [2] ();

	for (genvar i = 0; i < 2; i++) begin : g_port
		localparam logic [7:0] CTL_IDX = (i == 0) ?
			scpc_pkg::IDX_SP0_CTL : scpc_pkg::IDX_SP1_CTL;

		assign pif[i].wr_en = wr_sel && (wr_idx == CTL_IDX);
		assign pif[i].wr_data = w_data_ff;
		assign pif[i].fe_sel = fe_sel_ff[i];
		assign pif[i].rx_done = rx_done[i];
		assign pif[i].rx_stop = rx_stop[i];
		assign pif[i].rx_ninth = rx_ninth[i];
		assign pif[i].rx_match = rx_match[i];
		assign pif[i].tx_done = tx_done[i];
		assign view_w[i] = pif[i].view;
		assign mode_w[i] = pif[i].mode;
		assign allow_w[i] = pif[i].rx_allow;
		assign ninth_w[i] = pif[i].tx_ninth;

		scpc_port_ctl u_ctl (
			.clk (clk),
			.rst (rst),
			.pif (pif[i])
		);
	end

	// per-port outputs; the interrupt request is a level that stays up
	// while either flag is set, so software must clear both to drop it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= '0;
			rx_enable_ff <= 2'h0;
			tx_ninth_ff <= 2'h0;
			irq_req_ff <= 2'h0;
		end else begin
			mode_ff <= mode_w;
			rx_enable_ff <= allow_w;
			tx_ninth_ff <= ninth_w;
			for (int k = 0; k < 2; k++) begin
				irq_req_ff[k] <= irq_en_ff[k] && (view_w[k][scpc_pkg::B_TI] ||
					view_w[k][scpc_pkg::B_RI]);
			end
		end
	end

	// baud source selects for the shift engines
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p0_dbl_ff <= 1'b0;
			p1_div32_ff <= 1'b0;
			p1_tmr3_ff <= 1'b0;
			p1_len_ff <= scpc_pkg::LEN_SYNC;
		end else begin
			p0_dbl_ff <= baud_dbl_ff[0] && (mode_w[0] == 2'b10 ||
				(mode_w[0][0] && p0_timer1_src));
			p1_div32_ff <= baud_dbl_ff[1] && mode_w[1] == 2'b10;
			p1_tmr3_ff <= mode_w[1][0];
			p1_len_ff <= frame_len(mode_w[1]);
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = {24'h00_0000, rdata_ff};
	assign port_mode = mode_ff;
	assign rx_enable = rx_enable_ff;
	assign tx_ninth = tx_ninth_ff;
	assign irq_req = irq_req_ff;
	assign p0_baud_double = p0_dbl_ff;
	assign p1_div32 = p1_div32_ff;
	assign p1_clk_timer3 = p1_tmr3_ff;
	assign p1_frame_len = p1_len_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_p1_mode_write: assert property (
		pif[1].wr_en && !fe_sel_ff[1] ##1 1'b1
		|-> mode_w[1] == $past(w_data_ff[7:6]) ##1 port_mode[1] ==
		$past(w_data_ff[7:6], 2)
	) else $error("port 1 mode not taken from control write");
	chk_p1_mode_map: assert property (
		mode_w[1] == 2'b01 |=> p1_frame_len == scpc_pkg::LEN_10 &&
		p1_clk_timer3
	) else $error("port 1 mode 1 frame length or source wrong");
	for (genvar j = 0; j < 2; j++) begin : g_chk
		chk_fe_keeps_mode: assert property (
			pif[j].wr_en && fe_sel_ff[j] |=> $stable(mode_w[j][1])
		) else $error("frame error access changed the mode");
	end
	chk_rx_disabled: assert property (
		!view_w[1][scpc_pkg::B_REN] |=> !rx_enable[1]
	) else $error("reception enabled with enable bit clear");
	chk_sync_rx_hold: assert property (
		mode_w[1] == 2'b00 && view_w[1][scpc_pkg::B_RI] |=> !rx_enable[1]
	) else $error("mode 0 reception allowed with receive flag set");
	chk_tx_ninth: assert property (
		mode_w[1][1] |=> tx_ninth[1] == $past(view_w[1][scpc_pkg::B_TB8])
	) else $error("ninth transmit bit not passed on");
	chk_irq_request: assert property (
		irq_en_ff[1] && tx_done[1] ##1 irq_en_ff[1] |=> irq_req[1]
	) else $error("interrupt not requested after transmit flag set");
	chk_p0_double: assert property (
		baud_dbl_ff[0] && mode_w[0] == 2'b10 |=> p0_baud_double
	) else $error("port 0 mode 2 rate not doubled");
	chk_p1_div32: assert property (
		mode_w[1] == 2'b10 |=> p1_div32 == $past(baud_dbl_ff[1])
	) else $error("port 1 mode 2 divider select wrong");
	chk_write_resp: assert property (
		aw_hold_ff && w_hold_ff |=> s_axi_bvalid && !s_axi_awready
	) else $error("write response missing after address and data");
endmodule

//--- scpc_line_model.sv
`timescale 1ns/100ps
module scpc_line_model (
	input  wire logic       clk,      // system clock
	output logic      [1:0] rx_done,  // frame received pulse
	output logic      [1:0] rx_stop,  // sampled stop bit
	output logic      [1:0] rx_ninth, // received ninth bit
	output logic      [1:0] rx_match, // address matched
	output logic      [1:0] tx_done   // frame sent pulse
);
	initial begin
		rx_done = 2'h0;
		tx_done = 2'h0;
		rx_stop = 2'h3;
		rx_ninth = 2'h0;
		rx_match = 2'h0;
	end

	task automatic rx(input int p, input logic s, input logic n,
		input logic m);
		rx_done[p] <= 1'b1;
		rx_stop[p] <= s;
		rx_ninth[p] <= n;
		rx_match[p] <= m;
		@(posedge clk);
		rx_done[p] <= 1'b0;
		// qualifiers are stale after the pulse: show the inverse
		rx_stop[p] <= ~s;
		rx_ninth[p] <= ~n;
		rx_match[p] <= ~m;
	endtask

	task automatic tx(input int p);
		tx_done[p] <= 1'b1;
		@(posedge clk);
		tx_done[p] <= 1'b0;
	endtask
endmodule

//--- tb_scpc_top.sv
`timescale 1ns/100ps
module tb_scpc_top;
	localparam logic [11:0] A_IE = {2'b00, scpc_pkg::IDX_IRQ_EN, 2'b00};
	localparam logic [11:0] A_PW = {2'b00, scpc_pkg::IDX_PWR_BAUD, 2'b00};
	localparam logic [11:0] A_C0 = {2'b00, scpc_pkg::IDX_SP0_CTL, 2'b00};
	localparam logic [11:0] A_T3 = {2'b00, scpc_pkg::IDX_TMR3_CTL, 2'b00};
	localparam logic [11:0] A_C1 = {2'b00, scpc_pkg::IDX_SP1_CTL, 2'b00};
	logic            clk, rst, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	logic [11:0]     awa, ara;
	logic [31:0]     wd, rd_data;
	logic [3:0]      ws, flen;
	logic [1:0]      bresp, rresp, rxd, rxs, rxn, rxm, txd, ren, tn, irq, resp;
	logic [1:0][1:0] pm;
	logic            t1src, p0dbl, div32, ct3;
	logic [7:0]      rb;
	int              mismatches, checked, cyc;

	scpc_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd_data), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .rx_done(rxd), .rx_stop(rxs), .rx_ninth(rxn),
		.rx_match(rxm), .tx_done(txd), .p0_timer1_src(t1src),
		.port_mode(pm), .rx_enable(ren), .tx_ninth(tn), .irq_req(irq),
		.p0_baud_double(p0dbl), .p1_div32(div32), .p1_clk_timer3(ct3),
		.p1_frame_len(flen));
	scpc_line_model line (.clk(clk), .rx_done(rxd), .rx_stop(rxs),
		.rx_ninth(rxn), .rx_match(rxm), .tx_done(txd));

	task automatic results;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awa <= a;
		wd <= {24'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awv && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_rdy) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (bv !== 1'b1);
		resp = bresp;
		br <= 1'b0;
		// outputs follow the registers one edge later
		repeat (3) @(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rb = rd_data[7:0];
		resp = rresp;
		rr <= 1'b0;
		// an edge passes so a following read never re-drives rready now
		@(posedge clk);
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		rd(a);
		chk(32'(rb), 32'(e));
	endtask

	task automatic t_modes;
		logic [3:0] len[4];
		len = '{scpc_pkg::LEN_SYNC, scpc_pkg::LEN_10, scpc_pkg::LEN_11,
			scpc_pkg::LEN_11};
		chk(32'(flen), 32'(scpc_pkg::LEN_SYNC));
		rc(A_C1, scpc_pkg::RST_CTL);
		for (int m = 0; m < 4; m++) begin
			wr(A_C1, {m[1:0], 6'h00});
			chk(32'(pm[1]), 32'(m));
			chk(32'(flen), 32'(len[m]));
			chk(32'(ct3), 32'(m[0]));
		end
	endtask

	task automatic t_ninth;
		wr(A_C1, 8'h80);
		chk(32'(tn[1]), 32'h0000_0000);
		wr(A_C1, 8'h88);
		chk(32'(tn[1]), 32'h0000_0001);
		wr(A_C1, 8'h40);
		chk(32'(tn[1]), 32'h0000_0001);
	endtask

	task automatic t_ferr;
		wr(A_T3, 8'h40);
		wr(A_C1, 8'h40);
		line.rx(1, 1'b0, 1'b1, 1'b1);
		rc(A_C1, 8'hc1);
		rc(A_C1, 8'hc1);
		wr(A_T3, 8'h40);
		rc(A_C1, 8'hc1);
		wr(A_C1, 8'h40);
		rc(A_C1, 8'h40);
		chk(32'(pm[1]), 32'h0000_0001);
		line.rx(1, 1'b0, 1'b0, 1'b1);
		rc(A_C1, 8'hc1);
		wr(A_C1, 8'h40);
		wr(A_T3, 8'h00);
		rc(A_C1, 8'h40);
	endtask

	task automatic t_mproc;
		wr(A_C1, 8'he0);
		line.rx(1, 1'b1, 1'b0, 1'b1);
		rc(A_C1, 8'he0);
		line.rx(1, 1'b1, 1'b1, 1'b0);
		rc(A_C1, 8'he0);
		line.rx(1, 1'b1, 1'b1, 1'b1);
		rc(A_C1, 8'he5);
		wr(A_C1, 8'h60);
		line.rx(1, 1'b0, 1'b0, 1'b1);
		rc(A_C1, 8'h60);
		line.rx(1, 1'b1, 1'b0, 1'b1);
		rc(A_C1, 8'h65);
	endtask

	task automatic t_ren;
		wr(A_C1, 8'h10);
		chk(32'(ren[1]), 32'h0000_0001);
		line.rx(1, 1'b1, 1'b1, 1'b1);
		repeat (3) @(posedge clk);
		chk(32'(ren[1]), 32'h0000_0000);
		rc(A_C1, 8'h11);
		wr(A_C1, 8'h50);
		chk(32'(ren[1]), 32'h0000_0001);
		wr(A_C1, 8'h40);
		chk(32'(ren[1]), 32'h0000_0000);
	endtask

	task automatic t_irq;
		wr(A_IE, 8'h02);
		line.tx(1);
		repeat (3) @(posedge clk);
		chk(32'(irq[1]), 32'h0000_0001);
		rc(A_C1, 8'h42);
		wr(A_C1, 8'h40);
		chk(32'(irq[1]), 32'h0000_0000);
		wr(A_IE, 8'h00);
		line.tx(1);
		repeat (3) @(posedge clk);
		chk(32'(irq[1]), 32'h0000_0000);
		rc(A_C1, 8'h42);
	endtask

	task automatic t_baud;
		wr(A_T3, 8'h80);
		wr(A_C1, 8'h80);
		chk(32'(div32), 32'h0000_0001);
		wr(A_C1, 8'hc0);
		chk(32'(div32), 32'h0000_0000);
		wr(A_PW, 8'h80);
		wr(A_C0, 8'h80);
		chk(32'(p0dbl), 32'h0000_0001);
		chk(32'(pm[0]), 32'h0000_0002);
		chk(32'(tn[0]), 32'h0000_0000);
		wr(A_C0, 8'h40);
		chk(32'(p0dbl), 32'h0000_0000);
		t1src <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(p0dbl), 32'h0000_0001);
		wr(A_PW, 8'h40);
		line.rx(0, 1'b0, 1'b1, 1'b1);
		rc(A_C0, 8'hc1);
		wr(A_IE, 8'h01);
		chk(32'(irq[0]), 32'h0000_0001);
	endtask

	task automatic t_bus;
		rd(12'h3fc);
		chk(32'(resp), 32'(scpc_pkg::RESP_SLVERR));
		chk(32'(rb), 32'h0000_0000);
		wr(12'h3fc, 8'hff);
		chk(32'(resp), 32'(scpc_pkg::RESP_SLVERR));
		// lane 0 strobe low: the write is answered but must not land
		ws <= 4'he;
		wr(A_C1, 8'h00);
		chk(32'(resp), 32'(scpc_pkg::RESP_OKAY));
		ws <= 4'hf;
		rc(A_C1, 8'hc0);
		chk(32'(resp), 32'(scpc_pkg::RESP_OKAY));
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		rst = 1'b1;
		{awa, ara, wd, awv, wv, br, arv, rr, t1src} = '0;
		ws = 4'hf;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_modes();
		t_ninth();
		t_ferr();
		t_mproc();
		t_ren();
		t_irq();
		t_baud();
		t_bus();
		results();
	end
endmodule
